// ==== hdl/cbr_regs.v ====
/*
 Device-specific configuration bytes of the two-function card bridge,
 with the small control logic they steer.
 Assumes configuration strobes and status inputs come from logic on core_clk;
 only rst_n is asynchronous.
*/
`timescale 1ns/1ps
`include "cbr_map.vh"

module cbr_regs
#(
   parameter DISCARD_LONG_CYC = `CBR_DISCARD_LONG
)
(
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        cfg_wr,
   input  wire        cfg_rd,
   input  wire        cfg_func,
   input  wire [7:0]  cfg_addr,
   input  wire [7:0]  cfg_wdata,
   output reg  [7:0]  cfg_rdata_r,
   output reg         cfg_rvalid_r,
   input  wire        id_rd,
   input  wire [31:0] id_true,
   output reg  [31:0] id_rdata_r,
   output reg         id_rvalid_r,
   input  wire [1:0]  d3_state,
   input  wire [1:0]  pwr_down_req,
   output reg  [1:0]  sock_pwr_down_r,
   input  wire [1:0]  csc_event,
   input  wire [1:0]  legacy_803_b4,
   input  wire [7:0]  legacy_805_hi,
   output reg  [1:0]  csc_to_pci_r,
   output reg  [1:0]  video_model_std_r,
   output reg         low_voltage_capable_r,
   output reg  [1:0]  interrupt_signal_select_r,
   output reg         delayed_txn_off_r,
   output reg  [6:0]  latency_limit_r,
   input  wire        card_discard_run,
   input  wire        host_discard_run,
   output reg         card_discard_expired_r,
   output reg         host_discard_expired_r
);

   reg        rst_meta_r;
   reg        rst_sync_r;
   wire       rst_sync_n;

   // Global control bits, one copy
   reg        lvcap_r;
   reg        test3_r;
   reg  [1:0] imode_r;
   reg        test0_r;
   reg        idmask_r;
   reg        dtoff_r;
   reg        latx_r;
   reg        cardtim_r;
   reg        hosttim_r;

   // Per-function bits
   reg  [1:0] lock_r;
   reg  [1:0] iodiag_r;
   reg  [1:0] csc_r;
   reg  [1:0] video_r;

   reg  [15:0] card_cnt_r;
   reg  [15:0] host_cnt_r;

   wire       wr_dc;
   wire       wr_dg;
   wire       glob_ok;
   wire [15:0] long_lim;

   assign long_lim   = DISCARD_LONG_CYC[15:0];
   assign rst_sync_n = rst_sync_r;
   assign wr_dc      = cfg_wr && (cfg_addr == `CBR_OFF_DEVCTL);
   assign wr_dg      = cfg_wr && (cfg_addr == `CBR_OFF_DIAG);
   assign glob_ok    = (cfg_func == 1'b0);

   // Discard period limit from select bit
   function [15:0] discard_lim;
      input        sel;
      input [15:0] lng;
      begin
         discard_lim = sel ? `CBR_DISCARD_SHORT : lng;
      end
   endfunction

   // Read data for a byte offset seen by one function
   function [7:0] rd_byte;
      input [7:0] addr;
      input       fn;
      reg   [7:0] dc;
      reg   [7:0] dg;
      reg         g;
      begin
         dc = 8'h00;
         dg = 8'h00;
         g  = ~fn;
         dc[`CBR_DC_LOCK]     = lock_r[fn];
         dc[`CBR_DC_LVCAP]    = g & lvcap_r;
         dc[`CBR_DC_IODIAG]   = iodiag_r[fn];
         dc[`CBR_DC_RSVD]     = 1'b0;                    // [RULE_04]
         dc[`CBR_DC_TEST]     = g & test3_r;
         dc[`CBR_DC_IMODE_HI] = g & imode_r[1];
         dc[`CBR_DC_IMODE_LO] = g & imode_r[0];
         dc[`CBR_DC_TEST0]    = g & test0_r;
         dg[`CBR_DG_IDMASK]   = g & idmask_r;
         dg[`CBR_DG_ONE]      = 1'b1;                    // [RULE_11]
         dg[`CBR_DG_CSC]      = csc_r[fn];
         dg[`CBR_DG_DTOFF]    = g & dtoff_r;
         dg[`CBR_DG_LATX]     = g & latx_r;
         dg[`CBR_DG_CARDTIM]  = g & cardtim_r;
         dg[`CBR_DG_HOSTTIM]  = g & hosttim_r;
         dg[`CBR_DG_VIDEO]    = video_r[fn];
         case (addr)
            `CBR_OFF_DEVCTL : rd_byte = dc;
            `CBR_OFF_DIAG   : rd_byte = dg;
            `CBR_OFF_CAPID  : rd_byte = `CBR_CAPID_VAL;  // [RULE_18]
            `CBR_OFF_NEXT   : rd_byte = `CBR_NEXT_VAL;   // [RULE_19]
            default         : rd_byte = 8'h00;
         endcase
      end
   endfunction

   // Reset release through two flip-flops
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Global bits, written only through function 0
   always @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         lvcap_r   <= 1'b1;                              // [RULE_02]
         test3_r   <= 1'b0;
         imode_r   <= 2'h3;                              // [RULE_06]
         test0_r   <= 1'b0;
         idmask_r  <= 1'b0;
         dtoff_r   <= 1'b0;
         latx_r    <= 1'b0;
         cardtim_r <= 1'b0;
         hosttim_r <= 1'b0;
      end
      else
      begin
         if (wr_dc && glob_ok)                           // [RULE_08]
         begin
            lvcap_r <= cfg_wdata[`CBR_DC_LVCAP];
            test3_r <= cfg_wdata[`CBR_DC_TEST];          // [RULE_05]
            imode_r <= cfg_wdata[`CBR_DC_IMODE_HI:`CBR_DC_IMODE_LO];
            test0_r <= cfg_wdata[`CBR_DC_TEST0];         // [RULE_07]
         end
         if (wr_dg && glob_ok)                           // [RULE_08] [RULE_09]
         begin
            idmask_r  <= cfg_wdata[`CBR_DG_IDMASK];
            dtoff_r   <= cfg_wdata[`CBR_DG_DTOFF];
            latx_r    <= cfg_wdata[`CBR_DG_LATX];
            cardtim_r <= cfg_wdata[`CBR_DG_CARDTIM];
            hosttim_r <= cfg_wdata[`CBR_DG_HOSTTIM];
         end
      end
   end

   // Per-function bits and socket-side logic
   genvar f;
   generate
      for (f = 0; f < 2; f = f + 1)
      begin : g_fn
         always @(posedge core_clk or negedge rst_sync_n)
         begin
            if (!rst_sync_n)
            begin
               lock_r[f]            <= 1'b0;
               iodiag_r[f]          <= 1'b1;             // [RULE_03]
               csc_r[f]             <= 1'b1;
               video_r[f]           <= 1'b0;
               sock_pwr_down_r[f]   <= 1'b0;
               csc_to_pci_r[f]      <= 1'b0;
               video_model_std_r[f] <= 1'b1;
            end
            else
            begin
               // Control bit 4 and diagnostic bit 6 are never stored
               if (wr_dc && (cfg_func == f))             // [RULE_20]
               begin
                  lock_r[f]   <= cfg_wdata[`CBR_DC_LOCK];
                  iodiag_r[f] <= cfg_wdata[`CBR_DC_IODIAG];
               end
               if (wr_dg && (cfg_func == f))             // [RULE_20]
               begin
                  csc_r[f]   <= cfg_wdata[`CBR_DG_CSC];
                  video_r[f] <= cfg_wdata[`CBR_DG_VIDEO];
               end
               // Power-down refused while the lock bit is set in D3
               sock_pwr_down_r[f] <= pwr_down_req[f] && !(lock_r[f] && d3_state[f]); // [RULE_01]
               if (csc_r[f])
                  csc_to_pci_r[f] <= csc_event[f] &&
                                     (legacy_805_hi[f*4+3:f*4] == `CBR_LEGACY_ROUTE); // [RULE_12]
               else
                  csc_to_pci_r[f] <= csc_event[f] && legacy_803_b4[f]; // [RULE_12]
               video_model_std_r[f] <= ~video_r[f];      // [RULE_17]
            end
         end
      end
   endgenerate

   // Read path, global outputs and discard timers
   always @(posedge core_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         cfg_rdata_r               <= 8'h00;
         cfg_rvalid_r              <= 1'b0;
         id_rdata_r                <= 32'h00000000;
         id_rvalid_r               <= 1'b0;
         low_voltage_capable_r     <= 1'b1;
         interrupt_signal_select_r <= 2'h3;
         delayed_txn_off_r         <= 1'b0;
         latency_limit_r           <= `CBR_LAT_SHORT;
         card_cnt_r                <= 16'h0000;
         host_cnt_r                <= 16'h0000;
         card_discard_expired_r    <= 1'b0;
         host_discard_expired_r    <= 1'b0;
      end
      else
      begin
         cfg_rvalid_r <= cfg_rd;
         if (cfg_rd)
            cfg_rdata_r <= rd_byte(cfg_addr, cfg_func);
         id_rvalid_r <= id_rd;
         if (id_rd)
            id_rdata_r <= idmask_r ? 32'hffffffff : id_true; // [RULE_10]
         low_voltage_capable_r     <= lvcap_r;           // [RULE_02]
         interrupt_signal_select_r <= imode_r;           // [RULE_06]
         delayed_txn_off_r         <= dtoff_r;           // [RULE_13]
         latency_limit_r           <= latx_r ? `CBR_LAT_LONG : `CBR_LAT_SHORT; // [RULE_14]
         // Count while running; pulse on the last clock of the period
         card_discard_expired_r <= 1'b0;
         if (!card_discard_run)
            card_cnt_r <= 16'h0000;
         else if (card_cnt_r == discard_lim(cardtim_r, long_lim) - 16'h0001) // [RULE_15]
         begin
            card_cnt_r             <= 16'h0000;
            card_discard_expired_r <= 1'b1;
         end
         else
            card_cnt_r <= card_cnt_r + 16'h0001;
         host_discard_expired_r <= 1'b0;
         if (!host_discard_run)
            host_cnt_r <= 16'h0000;
         else if (host_cnt_r == discard_lim(hosttim_r, long_lim) - 16'h0001) // [RULE_16]
         begin
            host_cnt_r             <= 16'h0000;
            host_discard_expired_r <= 1'b1;
         end
         else
            host_cnt_r <= host_cnt_r + 16'h0001;
      end
   end

endmodule

// ==== pkg/cbr_map.vh ====
/*
 Offsets, field positions, reset values and timer counts for the bridge's
 device-specific configuration bytes. Assumes byte-wide configuration accesses.
*/
// Contract
// RULE_01: Power lock refuses socket power-down in D3
// RULE_02: Capability force bit reports 3-V capable; resets 1
// RULE_03: Legacy I/O diagnostic bit is RW, resets 1
// RULE_04: Control bit 4 always reads 0
// RULE_05: Host writes only 0 to test bit 3
// RULE_06: Interrupt mode field selects signaling; resets 11
// RULE_07: Host writes only 0 to control bit 0
// RULE_08: Global bits shared, reached only through function 0
// RULE_09: Host writes only zeros to diagnostic byte; the bench writes random values and 04h to 93h
// RULE_10: Mask bit makes ID reads all ones
// RULE_11: Diagnostic bit 6 always reads 1
// RULE_12: Status-change routing picks legacy condition for PCI
// RULE_13: Delayed-transaction disable bit turns delayed transactions off
// RULE_14: Latency extend bit stretches 16 to 64
// RULE_15: Card discard timer 2^10 or 2^15 clocks
// RULE_16: Host discard timer 2^10 or 2^15 clocks
// RULE_17: Video model bit 0 uses standard model
// RULE_18: Capability identifier reads 01h only
// RULE_19: Next-item pointer reads zeros only
// RULE_20: Writes to read-only bits are ignored
`ifndef CBR_MAP_VH
`define CBR_MAP_VH

`define CBR_OFF_DEVCTL      8'h92
`define CBR_OFF_DIAG        8'h93
`define CBR_OFF_CAPID       8'ha0
`define CBR_OFF_NEXT        8'ha1

`define CBR_DEVCTL_RST      8'h66
`define CBR_DIAG_RST        8'h60
`define CBR_CAPID_VAL       8'h01
`define CBR_NEXT_VAL        8'h00

`define CBR_DC_LOCK         7
`define CBR_DC_LVCAP        6
`define CBR_DC_IODIAG       5
`define CBR_DC_RSVD         4
`define CBR_DC_TEST         3
`define CBR_DC_IMODE_HI     2
`define CBR_DC_IMODE_LO     1
`define CBR_DC_TEST0        0

`define CBR_DG_IDMASK       7
`define CBR_DG_ONE          6
`define CBR_DG_CSC          5
`define CBR_DG_DTOFF        4
`define CBR_DG_LATX         3
`define CBR_DG_CARDTIM      2
`define CBR_DG_HOSTTIM      1
`define CBR_DG_VIDEO        0

`define CBR_LAT_SHORT       7'h10
`define CBR_LAT_LONG        7'h40
`define CBR_DISCARD_SHORT   16'h0400
`define CBR_DISCARD_LONG    32'h00008000
`define CBR_LEGACY_ROUTE    4'h0

`endif

// ==== tb/cbr_host_model.sv ====
/*
 Host side of the configuration bus: byte writes and reads.
 Assumes the bench calls its tasks; drives at the falling edge.
*/
`timescale 1ns/1ps
module cbr_host_model
(
   input  wire logic       core_clk,
   input  wire logic       cfg_rvalid_r,
   input  wire logic [7:0] cfg_rdata_r,
   output logic            cfg_wr,
   output logic            cfg_rd,
   output logic            cfg_func,
   output logic [7:0]      cfg_addr,
   output logic [7:0]      cfg_wdata
);
   initial
   begin
      {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_wdata} = 19'h0;
   end
   task automatic cfg_write(input logic fn, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {cfg_wr, cfg_func, cfg_addr} = {1'b1, fn, a};
      cfg_wdata = (a == 8'h92) ? (d & 8'hf6) : d;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~cfg_wdata;
   endtask
   task automatic cfg_read(input logic fn, input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      {cfg_rd, cfg_func, cfg_addr} = {1'b1, fn, a};
      @(negedge core_clk);
      cfg_rd = 1'b0;
      cfg_addr = ~a;
      while (cfg_rvalid_r !== 1'b1 && n < 4)
      begin
         @(negedge core_clk);
         n++;
      end
      d = (cfg_rvalid_r === 1'b1) ? cfg_rdata_r : 8'hxx;
   endtask
endmodule

// ==== tb/cbr_regs_chk_asserts.sv ====
/*
 Port checker for cbr_regs.
 Assumes bind to cbr_regs; requests start after reset release.
*/
`timescale 1ns/1ps
module cbr_regs_chk
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        cfg_rd,
   input wire logic        cfg_wr,
   input wire logic        cfg_func,
   input wire logic [7:0]  cfg_wdata,
   input wire logic [7:0]  cfg_addr,
   input wire logic [7:0]  cfg_rdata_r,
   input wire logic        cfg_rvalid_r,
   input wire logic        id_rd,
   input wire logic [31:0] id_true,
   input wire logic [31:0] id_rdata_r,
   input wire logic        id_rvalid_r,
   input wire logic [1:0]  d3_state,
   input wire logic [1:0]  pwr_down_req,
   input wire logic [1:0]  sock_pwr_down_r,
   input wire logic [6:0]  latency_limit_r,
   input wire logic        card_discard_run,
   input wire logic        host_discard_run,
   input wire logic        card_discard_expired_r,
   input wire logic        host_discard_expired_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic mask_r;
   // Copy of the ID mask bit, written through function 0 only
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_r <= 1'b0;
      else if (cfg_wr && !cfg_func && cfg_addr == 8'h93)
         mask_r <= cfg_wdata[7];
   end
   sequence s_rd(a);
      cfg_rd && cfg_addr == a;
   endsequence
   property p_capid; s_rd(8'ha0) |=> cfg_rvalid_r && cfg_rdata_r == 8'h01; endproperty
   a_capid: assert property (p_capid) else $error("capability_identifier wrong");
   property p_next; s_rd(8'ha1) |=> cfg_rvalid_r && cfg_rdata_r == 8'h00; endproperty
   a_next: assert property (p_next) else $error("next pointer wrong");
   property p_rsvd4; s_rd(8'h92) |=> !cfg_rdata_r[4]; endproperty
   a_rsvd4: assert property (p_rsvd4) else $error("control bit 4 set");
   property p_one6; s_rd(8'h93) |=> cfg_rdata_r[6]; endproperty
   a_one6: assert property (p_one6) else $error("diagnostic bit 6 clear");
   property p_idrd;
      id_rd |=> id_rvalid_r && id_rdata_r == ($past(mask_r) ? 32'hffffffff : $past(id_true));
   endproperty
   a_idrd: assert property (p_idrd) else $error("id answer wrong");
   property p_pwr; d3_state == 2'b00 |=> sock_pwr_down_r == $past(pwr_down_req); endproperty
   a_pwr: assert property (p_pwr) else $error("power down outside D3 wrong");
   property p_noreq; pwr_down_req == 2'b00 |=> sock_pwr_down_r == 2'b00; endproperty
   a_noreq: assert property (p_noreq) else $error("power down without request");
   property p_lat; latency_limit_r == 7'h10 || latency_limit_r == 7'h40; endproperty
   a_lat: assert property (p_lat) else $error("latency limit illegal");
   property p_hexp; host_discard_expired_r |-> $past(host_discard_run) ##1 !host_discard_expired_r; endproperty
   a_hexp: assert property (p_hexp) else $error("host discard pulse wrong");
   property p_cexp; card_discard_expired_r |-> $past(card_discard_run) ##1 !card_discard_expired_r; endproperty
   a_cexp: assert property (p_cexp) else $error("card discard pulse wrong");
endmodule
bind cbr_regs cbr_regs_chk cbr_regs_chk_i (.core_clk(core_clk), .rst_n(rst_n), .cfg_rd(cfg_rd),
   .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_wdata(cfg_wdata),
   .cfg_addr(cfg_addr), .cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r), .id_rd(id_rd),
   .id_true(id_true), .id_rdata_r(id_rdata_r), .id_rvalid_r(id_rvalid_r), .d3_state(d3_state),
   .pwr_down_req(pwr_down_req), .sock_pwr_down_r(sock_pwr_down_r), .latency_limit_r(latency_limit_r),
   .card_discard_run(card_discard_run), .host_discard_run(host_discard_run),
   .card_discard_expired_r(card_discard_expired_r), .host_discard_expired_r(host_discard_expired_r));

// ==== tb/tb.sv ====
/*
 Self-checking bench for cbr_regs with random accesses.
 Assumes the host model and the port checker.
*/
`timescale 1ns/1ps
module tb;
   logic        core_clk, rst_n, cfg_wr, cfg_rd, cfg_func, id_rd, cfg_rvalid_r, id_rvalid_r;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_r, legacy_805_hi, a, d, q;
   logic [31:0] id_true, id_rdata_r, seed;
   logic [1:0]  d3_state, pwr_down_req, sock_pwr_down_r, csc_event, legacy_803_b4, csc_to_pci_r;
   logic [1:0]  video_model_std_r, interrupt_signal_select_r, e2;
   logic        low_voltage_capable_r, delayed_txn_off_r, card_discard_run, host_discard_run, fn;
   logic        card_discard_expired_r, host_discard_expired_r;
   logic [6:0]  latency_limit_r;
   logic [7:0]  g92 = 8'h46, g93 = 8'h00, p92 [2] = '{8'h20, 8'h20}, p93 [2] = '{8'h20, 8'h20};
   logic [7:0]  tab [5] = '{8'h92, 8'h93, 8'ha0, 8'ha1, 8'h94};
   int          error_cnt = 0, compares = 0, cyc = 0, i, nc, nh;
   cbr_regs #(.DISCARD_LONG_CYC(64)) cbr_regs_i (.*);
   cbr_host_model cbr_host_model_i (.*);
   function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic f);
      if (ad == 8'h92) return (f ? 8'h00 : g92) | p92[f];
      if (ad == 8'h93) return (f ? 8'h00 : g93) | p93[f] | 8'h40;
      return (ad == 8'ha0) ? 8'h01 : 8'h00;
   endfunction
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic f);
      cbr_host_model_i.cfg_read(f, ad, q);
      chk8("cfg_rdata", exp_rd(ad, f), q);
   endtask
   task automatic report_and_stop;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial
   begin
      seed = 32'hac68;
      {id_rd, id_true, d3_state, pwr_down_req, csc_event, legacy_803_b4, legacy_805_hi} = 0;
      {card_discard_run, host_discard_run, rst_n} = 0;
      repeat (5) @(negedge core_clk);
      rst_n = 1;
      repeat (3) @(negedge core_clk);
      for (i = 0; i < 10; i++) rd_chk(tab[i % 5], i / 5);
      $display("test reset values done");
      for (i = 0; i < 60; i++)
      begin
         a = tab[$unsigned($random(seed)) % 5];
         fn = $random(seed);
         d = (i < 2) ? 8'hff : $random(seed);
         cbr_host_model_i.cfg_write(fn, a, d);
         if (a == 8'h92 && !fn) g92 = d & 8'h46;
         if (a == 8'h92) p92[fn] = d & 8'ha0;
         if (a == 8'h93 && !fn) g93 = d & 8'h9e;
         if (a == 8'h93) p93[fn] = d & 8'h21;
         {d3_state, pwr_down_req, csc_event, legacy_803_b4, legacy_805_hi} = $random(seed);
         id_true = $random(seed);
         id_rd = 1;
         @(negedge core_clk);
         id_rd = 0;
         @(negedge core_clk);
         chk32("id_rdata", g93[7] ? 32'hffffffff : id_true, id_rdata_r);
         chk8("imode", g92[2:1], interrupt_signal_select_r);
         chk8("lvcap", g92[6], low_voltage_capable_r);
         chk8("dt_off", g93[4], delayed_txn_off_r);
         chk8("latency", g93[3] ? 8'h40 : 8'h10, latency_limit_r);
         chk8("video", {~p93[1][0], ~p93[0][0]}, video_model_std_r);
         chk8("sock_pwr", pwr_down_req & ~({p92[1][7], p92[0][7]} & d3_state), sock_pwr_down_r);
         e2[0] = p93[0][5] ? (legacy_805_hi[3:0] == 4'h0) : legacy_803_b4[0];
         e2[1] = p93[1][5] ? (legacy_805_hi[7:4] == 4'h0) : legacy_803_b4[1];
         chk8("csc", csc_event & e2, csc_to_pci_r);
         rd_chk(a, 0);
         rd_chk(a, 1);
      end
      $display("test random accesses done");
      cbr_host_model_i.cfg_write(0, 8'h93, 8'h04);
      g93 = 8'h04;
      p93[0] = 8'h00;
      {card_discard_run, host_discard_run} = 2'b11;
      nc = 0;
      nh = 0;
      for (i = 1; i <= 1100; i++)
      begin
         @(negedge core_clk);
         if (card_discard_expired_r === 1'b1 && nc == 0) nc = i;
         if (host_discard_expired_r === 1'b1 && nh == 0) nh = i;
      end
      chk32("card_period", 1024, nc);
      chk32("host_period", 64, nh);
      $display("test discard timers done");
      cbr_host_model_i.cfg_write(0, 8'h93, 8'h00);
      g93 = 8'h00;
      rd_chk(8'h93, 0);
      $display("test zero write done");
      report_and_stop;
   end
endmodule
